// ### hw/scale_integer_slot_interface.sv
// Purpose: Integer slot exchange between scale logic and a controller
// Assumes: Controller side reaches slot words over the register port
// Notes: Commands act at each interface update strobe
`timescale 1ns/1ns
`default_nettype none
module scale_integer_slot_interface (
   input wire logic core_clk, // Clock, 10 MHz
   input wire logic nrst, // Async reset, active low
   input wire logic [7:0] addr, // Register byte address
   input wire logic [15:0] wrData, // Write data
   input wire logic wrStb, // Write strobe
   input wire logic rdStb, // Read strobe
   output logic [15:0] rdData, // Read data, cycle after strobe
   input wire logic updateTick, // Interface update cycle pulse
   input wire slot_pkg::weights_t weights, // Live weights
   input wire slot_pkg::scale_state_t scaleState, // Scale conditions
   input wire logic [2:0] outputsOwned, // Outputs held by own logic
   input wire logic [2:0] ownOutputs, // Own logic output levels
   output logic [2:0] hwOutputs, // Hardware output levels
   output slot_pkg::cmd_pulses_t cmdPulses, // One-cycle command events
   output logic [15:0] tareValue, // Tare register
   output logic [15:0] targetValue, // Target register
   output logic netMode, // Net mode
   output logic [2:0] messageCode, // message_mode_code value
   output logic promptStartTrigger, // Prompt sequence request
   output logic divisionFormat // Values are divisions
);
   import slot_pkg::*;

   // ****************************************
   // Update sequencer
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LATCH = 3'b010,
      ST_PUBLISH = 3'b100
   } seq_state_t;

   seq_state_t seqState;
   seq_state_t next_seqState;
   logic [15:0] downHold [NUM_SLOTS];
   logic [15:0] cmdHold [NUM_SLOTS];
   logic [15:0] cmdLive [NUM_SLOTS];
   logic [15:0] cmdPrev;
   logic [15:0] weightOut [NUM_SLOTS];
   logic [15:0] statusOut [NUM_SLOTS];
   logic [15:0] weightNew [NUM_SLOTS];
   logic [15:0] statusNew [NUM_SLOTS];
   logic [1:0] slotCountCfg;
   logic enterLatched;
   logic updating;
   logic ctrlHit;
   logic [15:0] cmd0;
   logic [15:0] rise;
   logic [15:0] fall;
   logic msgLeaveZero;
   logic msgChanged;
   logic [SLOT_IDX_W-1:0] wrSlot;
   logic [3:0] wrField;
   logic slotSpace;

   // Slot address decode, used by reads and writes
   function automatic logic inSlotSpace(input logic [7:0] a);
      // Upper bound stops addresses past the last slot aliasing slot one
      inSlotSpace = (a >= OFS_SLOT_BASE) && (a[1:0] == 2'h0)
                  && (a < OFS_SLOT_BASE + 8'(NUM_SLOTS << SLOT_STRIDE_SH));
   endfunction : inSlotSpace

   function automatic logic [SLOT_IDX_W-1:0] slotOf(input logic [7:0] a);
      logic [7:0] off;
      off = a - OFS_SLOT_BASE;
      slotOf = off[SLOT_STRIDE_SH +: SLOT_IDX_W];
   endfunction : slotOf

   assign slotSpace = inSlotSpace(addr);
   assign wrSlot = slotOf(addr);
   assign wrField = addr[3:0];

   // Sequencer: latch commands, then publish words; bit 14 high through both
   always_comb begin
      case (seqState)
         ST_IDLE: next_seqState = updateTick ? ST_LATCH : ST_IDLE;
         ST_LATCH: next_seqState = ST_PUBLISH;
         ST_PUBLISH: next_seqState = ST_IDLE;
         default: next_seqState = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         seqState <= ST_IDLE;
      end else begin
         seqState <= next_seqState;
      end
   end

   assign updating = (seqState != ST_IDLE);

   // ****************************************
   // Controller words
   // ****************************************
   // Command writes land in live copies that only the sequencer moves inward; down words are used as written
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int s = 0; s < NUM_SLOTS; s++) begin
            downHold[s] <= 16'h0000;
            cmdLive[s] <= 16'h0000;
         end
      end else if (wrStb && slotSpace) begin
         if (wrField == SLOT_DOWN) begin
            downHold[wrSlot] <= wrData;
         end else if (wrField == SLOT_CMD) begin
            cmdLive[wrSlot] <= wrData;
         end
      end
   end

   // Command snapshot per update, so edges align to update cycles
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int s = 0; s < NUM_SLOTS; s++) begin
            cmdHold[s] <= 16'h0000;
         end
         cmdPrev <= 16'h0000;
      end else if (seqState == ST_LATCH) begin
         cmdPrev <= cmdHold[0];
         for (int s = 0; s < NUM_SLOTS; s++) begin
            cmdHold[s] <= cmdLive[s];
         end
      end
   end

   // Configuration: slot count and division format
   assign ctrlHit = wrStb && (addr == OFS_CTRL);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         slotCountCfg <= CTRL_COUNT_RST;
         divisionFormat <= 1'b0;
      end else if (ctrlHit) begin
         slotCountCfg <= wrData[CTRL_COUNT_LSB +: 2];
         divisionFormat <= wrData[CTRL_DIV_BIT];
      end
   end

   // ****************************************
   // Edge detection, slot one only
   // ****************************************
   assign cmd0 = cmdHold[0];
   assign rise = cmd0 & ~cmdPrev;
   assign fall = ~cmd0 & cmdPrev;
   assign msgLeaveZero = (cmdPrev[CMD_MSG_LSB +: MSG_W] == 3'h0)
                       && (cmd0[CMD_MSG_LSB +: MSG_W] != 3'h0);
   assign msgChanged = cmd0[CMD_MSG_LSB +: MSG_W] != cmdPrev[CMD_MSG_LSB +: MSG_W];

   // Command pulses, one cycle, set at the end of the publish step
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cmdPulses <= '0;
      end else if (seqState == ST_PUBLISH) begin
         cmdPulses.loadTare <= rise[CMD_LOAD_TARE];
         cmdPulses.clearTare <= rise[CMD_CLR_TARE];
         cmdPulses.tareNow <= rise[CMD_TARE] && !scaleState.motion;
         cmdPulses.print <= rise[CMD_PRINT];
         cmdPulses.zero <= rise[CMD_ZERO];
         cmdPulses.targetStart <= rise[CMD_TARGET_RUN];
         cmdPulses.targetAbort <= fall[CMD_TARGET_RUN];
         cmdPulses.loadTarget <= rise[CMD_LOAD_TARGET];
         cmdPulses.messageStart <= msgLeaveZero;
      end else begin
         cmdPulses <= '0;
      end
   end

   // Tare register and net mode; load beats clear if both rise
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tareValue <= 16'h0000;
         netMode <= 1'b0;
      end else if (seqState == ST_PUBLISH) begin
         if (rise[CMD_LOAD_TARE]) begin
            tareValue <= downHold[0];
            netMode <= 1'b1;
         end else if (rise[CMD_TARE] && !scaleState.motion) begin
            tareValue <= weights.gross;
            netMode <= 1'b1;
         end else if (rise[CMD_CLR_TARE]) begin
            tareValue <= 16'h0000;
            netMode <= 1'b0;
         end
      end
   end

   // Target register, used at the next start
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         targetValue <= 16'h0000;
      end else if (seqState == ST_PUBLISH && rise[CMD_LOAD_TARGET]) begin
         targetValue <= downHold[0];
      end
   end

   // Message code and prompt trigger; a new code only out of zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         messageCode <= 3'h0;
         promptStartTrigger <= 1'b0;
      end else if (seqState == ST_PUBLISH && msgLeaveZero) begin
         messageCode <= cmd0[CMD_MSG_LSB +: MSG_W];
         promptStartTrigger <= (cmd0[CMD_MSG_LSB +: MSG_W] == MSG_PROMPT);
      end
   end

   // Enter key flag; a key press wins over a same-cycle clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         enterLatched <= 1'b0;
      end else if (scaleState.enterKey) begin
         enterLatched <= 1'b1;
      end else if (seqState == ST_PUBLISH && msgChanged) begin
         enterLatched <= 1'b0;
      end
   end

   // Hardware outputs; owned outputs keep the indicator's own level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hwOutputs <= 3'h0;
      end else begin
         hwOutputs <= (outputsOwned & ownOutputs)
                    | (~outputsOwned & cmd0[CMD_OUT_LSB +: 3]);
      end
   end

   // ****************************************
   // Outgoing words
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : gSlot
         slot_word_builder uBuild (
            .select(cmdHold[g][CMD_SEL_LSB +: SEL_W]),
            .weights(weights),
            .tareValue(tareValue),
            .targetValue(targetValue),
            .state(scaleState),
            .enterLatched(enterLatched),
            .netMode(netMode),
            .updating(1'b0),
            .weightWord(weightNew[g]),
            .statusWord(statusNew[g])
         );
      end
   endgenerate

   // Publish only slots within the configured count; others read zero, except status bit 14 during an update
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int s = 0; s < NUM_SLOTS; s++) begin
            weightOut[s] <= 16'h0000;
            statusOut[s] <= 16'h0000;
         end
      end else if (seqState == ST_PUBLISH) begin
         for (int s = 0; s < NUM_SLOTS; s++) begin
            if (s <= int'(slotCountCfg)) begin
               weightOut[s] <= weightNew[s];
               statusOut[s] <= statusNew[s];
            end else begin
               weightOut[s] <= 16'h0000;
               statusOut[s] <= 16'h0000;
            end
         end
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   // Unmapped addresses and write-only words read zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdData <= 16'h0000;
      end else if (rdStb) begin
         rdData <= 16'h0000;
         if (addr == OFS_CTRL) begin
            rdData <= {13'h0000, divisionFormat, slotCountCfg};
         end else if (addr == OFS_STAT) begin
            rdData <= {13'h0000, cmd0[CMD_TARGET_RUN], netMode, updating};
         end else if (addr == OFS_TARE) begin
            rdData <= tareValue;
         end else if (addr == OFS_TARGET) begin
            rdData <= targetValue;
         end else if (slotSpace && wrField == SLOT_WGT) begin
            rdData <= weightOut[wrSlot];
         end else if (slotSpace && wrField == SLOT_STS) begin
            rdData <= statusOut[wrSlot] | (updating ? 16'h4000 : 16'h0000);
         end
      end else begin
         rdData <= 16'h0000;
      end
   end
endmodule : scale_integer_slot_interface
`default_nettype wire

// ### hw/slot_pkg.sv
// Purpose: Shared constants and types for the slot exchange block
// Assumes: One clock, core_clk at 10 MHz
// Notes: Words are 16 bits; up to four slots
package slot_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_SLOTS = 4;
   localparam int WORD_W = 16;
   localparam int SLOT_IDX_W = 2;
   localparam int SEL_W = 3;
   localparam int MSG_W = 3;

   // ****************************************
   // Register offsets (byte addresses, word index times four)
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_TARE = 8'h08;
   localparam logic [7:0] OFS_TARGET = 8'h0c;
   localparam logic [7:0] OFS_SLOT_BASE = 8'h10;
   localparam int SLOT_STRIDE_SH = 4;
   localparam logic [3:0] SLOT_DOWN = 4'h0;
   localparam logic [3:0] SLOT_CMD = 4'h4;
   localparam logic [3:0] SLOT_WGT = 4'h8;
   localparam logic [3:0] SLOT_STS = 4'hc;

   // ****************************************
   // Control register fields
   // ****************************************
   localparam int CTRL_COUNT_LSB = 0;
   localparam int CTRL_DIV_BIT = 2;
   localparam int CTRL_STAT_UPD_BIT = 0;
   localparam int CTRL_STAT_NET_BIT = 1;
   localparam int CTRL_STAT_TGT_BIT = 2;
   localparam logic [1:0] CTRL_COUNT_RST = 2'h3;

   // ****************************************
   // Command word fields
   // ****************************************
   localparam int CMD_SEL_LSB = 0;
   localparam int CMD_LOAD_TARE = 3;
   localparam int CMD_CLR_TARE = 4;
   localparam int CMD_TARE = 5;
   localparam int CMD_PRINT = 6;
   localparam int CMD_ZERO = 7;
   localparam int CMD_TARGET_RUN = 8;
   localparam int CMD_MSG_LSB = 9;
   localparam int CMD_OUT_LSB = 12;
   localparam int CMD_LOAD_TARGET = 15;

   // ****************************************
   // Status word fields
   // ****************************************
   localparam int ST_TGT_LSB = 0;
   localparam int ST_CMP_LSB = 3;
   localparam int ST_ENTER = 8;
   localparam int ST_IN_LSB = 9;
   localparam int ST_MOTION = 12;
   localparam int ST_NET = 13;
   localparam int ST_UPDATING = 14;
   localparam int ST_DATA_OK = 15;

   // ****************************************
   // Select codes and message codes
   // ****************************************
   typedef enum logic [2:0] {
      SEL_GROSS = 3'h0,
      SEL_NET = 3'h1,
      SEL_DISPLAYED = 3'h2,
      SEL_TARE = 3'h3,
      SEL_TARGET = 3'h4,
      SEL_RATE = 3'h5
   } select_code_t;
   localparam logic [2:0] MSG_PROMPT = 3'h6;
   localparam logic [2:0] MSG_NUMERIC = 3'h7;

   // Retry time the controller waits for a tare
   localparam int TARE_RETRY_MS = 3;
   localparam int CLK_HZ = 10000000;
   localparam int TARE_RETRY_CYC = TARE_RETRY_MS * (CLK_HZ / 1000) * 1000;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [WORD_W-1:0] gross;
      logic [WORD_W-1:0] net;
      logic [WORD_W-1:0] displayed;
      logic [WORD_W-1:0] rate;
   } weights_t;

   typedef struct packed {
      logic [2:0] targetState;
      logic [4:0] comparators;
      logic [2:0] hwInputs;
      logic motion;
      logic normal;
      logic enterKey;
   } scale_state_t;

   typedef struct packed {
      logic loadTare;
      logic clearTare;
      logic tareNow;
      logic print;
      logic zero;
      logic targetStart;
      logic targetAbort;
      logic loadTarget;
      logic messageStart;
   } cmd_pulses_t;
endpackage : slot_pkg

// ### hw/slot_word_builder.sv
// Purpose: Builds one slot's weight and status words
// Assumes: Inputs steady within a cycle
// Notes: Pure combinational
`timescale 1ns/1ns
`default_nettype none
module slot_word_builder (
   input wire logic [2:0] select, // Slot select field
   input wire slot_pkg::weights_t weights, // Live weights
   input wire logic [15:0] tareValue, // Tare register
   input wire logic [15:0] targetValue, // Target register
   input wire slot_pkg::scale_state_t state, // Scale conditions
   input wire logic enterLatched, // Sticky enter flag
   input wire logic netMode, // Net mode
   input wire logic updating, // Refresh in progress
   output logic [15:0] weightWord, // Reported value
   output logic [15:0] statusWord // Status bits
);
   import slot_pkg::*;

   // Value choice; unknown codes fall back to gross
   always_comb begin
      case (select)
         SEL_NET: weightWord = weights.net;
         SEL_DISPLAYED: weightWord = weights.displayed;
         SEL_TARE: weightWord = tareValue;
         SEL_TARGET: weightWord = targetValue;
         SEL_RATE: weightWord = weights.rate;
         default: weightWord = weights.gross;
      endcase
      if (!state.normal) begin
         weightWord = 16'h0000;
      end
   end

   // Status packing
   always_comb begin
      statusWord = 16'h0000;
      statusWord[ST_TGT_LSB +: 3] = state.targetState;
      for (int i = 0; i < 5; i++) begin
         statusWord[ST_CMP_LSB + i] = state.comparators[4 - i];
      end
      statusWord[ST_ENTER] = enterLatched;
      statusWord[ST_IN_LSB +: 3] = state.hwInputs;
      statusWord[ST_MOTION] = state.motion;
      statusWord[ST_NET] = netMode;
      statusWord[ST_UPDATING] = updating;
      statusWord[ST_DATA_OK] = state.normal;
   end
endmodule : slot_word_builder
`default_nettype wire

// ### tb/plc_model.sv
// Purpose: Controller model on the slot register port
// Assumes: Read data stand one cycle after the strobe
// Notes: Called by the bench; released lines show inverted values
`timescale 1ns/1ns
`default_nettype none
module plc_model (
   input wire logic core_clk, // Clk
   output logic [7:0] addr, // Adr
   output logic [15:0] wrData, // Wd
   output logic wrStb, // Ws
   output logic rdStb, // Rs
   input wire logic [15:0] rdData // Rd
);
   import slot_pkg::*;
   initial begin
      addr = 8'hff;
      wrData = 16'h0000;
      wrStb = 1'b0;
      rdStb = 1'b0;
   end
   // One write cycle, then lines released
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge core_clk);
      wrStb <= 1'b0;
      addr <= ~a;
      wrData <= ~d;
   endtask : wr
   // One read cycle; data taken in the cycle after
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge core_clk);
      rdStb <= 1'b0;
      addr <= ~a;
      #1;
      d = rdData;
   endtask : rd
   // Value goes down before the command that uses it
   task automatic load(input logic [15:0] v, input logic [15:0] c);
      wr(OFS_SLOT_BASE + SLOT_DOWN, v);
      wr(OFS_SLOT_BASE + SLOT_CMD, c);
   endtask : load
endmodule : plc_model
`default_nettype wire

// ### tb/slot_iface_properties.sv
// Purpose: Port checks for the slot exchange block
// Assumes: One clock, async low reset
// Notes: Shadows slot one words seen on the write port
`timescale 1ns/1ns
`default_nettype none
module slot_iface_checker (
   input wire logic core_clk, // Clk
   input wire logic nrst, // Rst
   input wire logic [7:0] addr, // Adr
   input wire logic [15:0] wrData, // Wd
   input wire logic wrStb, // Ws
   input wire logic rdStb, // Rs
   input wire logic [15:0] rdData, // Rd
   input wire logic updateTick, // Tick
   input wire slot_pkg::weights_t weights, // Wt
   input wire slot_pkg::scale_state_t scaleState, // St
   input wire logic [2:0] outputsOwned, // Own
   input wire logic [2:0] ownOutputs, // Lvl
   input wire logic [2:0] hwOutputs, // Out
   input wire slot_pkg::cmd_pulses_t cmdPulses, // Ev
   input wire logic [15:0] tareValue, // Tare
   input wire logic [15:0] targetValue, // Tgt
   input wire logic netMode, // Net
   input wire logic [2:0] messageCode, // Msg
   input wire logic promptStartTrigger, // Prm
   input wire logic divisionFormat // Div
);
   import slot_pkg::*;
   // ****************
   // Shadow state
   // ****************
   logic [15:0] cmd1;
   logic [15:0] dl1;
   logic [3:0] sinceTick;
   logic [2:0] expOut;
   logic divBit;
   logic [15:0] cmdSnap;
   logic [1:0] upPh;
   assign divBit = wrData[CTRL_DIV_BIT];
   assign expOut = (cmdSnap[14:12] & ~outputsOwned) | (ownOutputs & outputsOwned);
   // Slot one words live inside the design, so mirror them here
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cmd1 <= 16'h0000;
         dl1 <= 16'h0000;
      end else if (wrStb && addr == OFS_SLOT_BASE + SLOT_CMD) begin
         cmd1 <= wrData;
      end else if (wrStb && addr == OFS_SLOT_BASE + SLOT_DOWN) begin
         dl1 <= wrData;
      end
   end
   // Cycles since the last tick; saturates so it never wraps
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) sinceTick <= 4'hf;
      else if (updateTick) sinceTick <= 4'h0;
      else if (sinceTick != 4'hf) sinceTick <= sinceTick + 4'h1;
   end
   // Update walk mirror; outputs follow the command latched one cycle after a tick
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         upPh <= 2'h0;
         cmdSnap <= 16'h0000;
      end else begin
         if (upPh == 2'h1) begin
            cmdSnap <= cmd1;
         end
         upPh <= (upPh == 2'h0) ? {1'b0, updateTick} : ((upPh == 2'h1) ? 2'h2 : 2'h0);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ****************
   // Properties
   // ****************
   AST_RD_IDLE: assert property (!$past(rdStb) |-> rdData == 16'h0000)
      else $error("read data not zero when idle");
   AST_UNMAPPED: assert property (rdStb && addr >= 8'h50 |=> rdData == 16'h0000)
      else $error("unmapped read not zero");
   AST_DIV: assert property (wrStb && addr == OFS_CTRL |=> divisionFormat == $past(divBit))
      else $error("division format not taken");
   AST_PULSE_TIME: assert property (cmdPulses != 9'h000 |-> sinceTick <= 4'h4)
      else $error("event outside an update");
   AST_LOAD_TARE: assert property (cmdPulses.loadTare |-> ##[0:1] (tareValue == dl1 && netMode))
      else $error("tare load wrong");
   AST_CLR_TARE: assert property (cmdPulses.clearTare && !cmdPulses.loadTare && !cmdPulses.tareNow
      |-> ##[0:1] (tareValue == 16'h0000 && !netMode)) else $error("tare clear wrong");
   AST_TARE_STILL: assert property (cmdPulses.tareNow |-> !scaleState.motion)
      else $error("tare taken in motion");
   AST_LOAD_TGT: assert property (cmdPulses.loadTarget |-> ##[0:1] targetValue == dl1)
      else $error("target load wrong");
   AST_MSG: assert property (cmdPulses.messageStart |-> ##[0:1] (messageCode == cmdSnap[11:9]
      && (cmdSnap[11:9] != MSG_PROMPT || promptStartTrigger))) else $error("message code wrong");
   AST_OUT: assert property (expOut == $past(expOut) && expOut == $past(expOut, 2)
      |-> hwOutputs == expOut) else $error("hardware outputs wrong");
endmodule : slot_iface_checker
`default_nettype wire

// ### tb/tb_scale_integer_slot_interface.sv
// Purpose: Self-checking bench for the slot exchange block
// Assumes: Update walk ends two cycles after the tick is sampled
// Notes: Select cases run from a table, the rest by hand
`timescale 1ns/1ns
`default_nettype none
module tb_scale_integer_slot_interface;
   import slot_pkg::*;
   typedef struct {int s; logic [2:0] sel; logic [15:0] e;} row_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr;
   logic [15:0] wrData, rdData, tareValue, targetValue, r;
   logic wrStb, rdStb, updateTick, netMode, promptStartTrigger, divisionFormat;
   logic [2:0] outputsOwned, ownOutputs, hwOutputs, messageCode;
   weights_t weights;
   scale_state_t scaleState;
   cmd_pulses_t cmdPulses, seen;
   int bad_count = 0;
   int compares = 0;
   // Select per slot; tare and target are loaded first
   row_t rows [8] = '{'{0, 3'h0, 16'h0101}, '{1, 3'h1, 16'hff02}, '{2, 3'h2, 16'h0303},
      '{3, 3'h3, 16'h1234}, '{0, 3'h4, 16'h0777}, '{1, 3'h5, 16'h0505},
      '{2, 3'h6, 16'h0101}, '{3, 3'h7, 16'h0101}};
   always #50 core_clk = ~core_clk;
   // Events since the last tick; the tick clears, avoiding a race
   always @(posedge core_clk) seen <= updateTick ? 9'h000 : seen | cmdPulses;
   scale_integer_slot_interface DUT (.core_clk, .nrst, .addr, .wrData, .wrStb, .rdStb, .rdData,
      .updateTick, .weights, .scaleState, .outputsOwned, .ownOutputs, .hwOutputs, .cmdPulses,
      .tareValue, .targetValue, .netMode, .messageCode, .promptStartTrigger, .divisionFormat);
   plc_model PLC (.core_clk, .addr, .wrData, .wrStb, .rdStb, .rdData);
   function automatic logic [7:0] sa(input int s, input logic [3:0] o);
      return OFS_SLOT_BASE + 8'(s << SLOT_STRIDE_SH) + 8'(o);
   endfunction : sa
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic upd();
      @(posedge core_clk) updateTick <= 1'b1;
      @(posedge core_clk) updateTick <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : upd
   task automatic cm(input logic [15:0] c);
      PLC.wr(sa(0, SLOT_CMD), c);
      upd();
   endtask : cm
   task automatic done(input string n);
      $display("test %s done", n);
   endtask : done
   task automatic end_sim();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // Cut a hang short; the run needs a small part of this
   initial begin
      #2000000;
      bad_count++;
      end_sim();
   end
   initial begin
      updateTick = 1'b0;
      weights = {16'h0101, 16'hff02, 16'h0303, 16'h0505};
      scaleState = {3'h5, 5'h03, 3'h6, 1'b0, 1'b1, 1'b0};
      outputsOwned = 3'h0;
      ownOutputs = 3'h0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      chk({tareValue[12:0], hwOutputs}, 16'h0000);
      PLC.load(16'h1234, 16'h0008);
      upd();
      chk(tareValue, 16'h1234);
      chk({7'h00, seen}, 16'h0100);
      PLC.load(16'h0777, 16'h8008);
      upd();
      chk(targetValue, 16'h0777);
      chk({7'h00, seen}, 16'h0002);
      done("load");
      foreach (rows[i]) begin
         PLC.wr(sa(rows[i].s, SLOT_CMD), (rows[i].s == 0 ? 16'h8008 : 16'h0000) | rows[i].sel);
         upd();
         PLC.rd(sa(rows[i].s, SLOT_WGT), r);
         chk(r, rows[i].e);
      end
      PLC.rd(sa(0, SLOT_STS), r);
      chk(r, 16'hacc5);
      @(posedge core_clk) updateTick <= 1'b1;
      @(posedge core_clk) updateTick <= 1'b0;
      PLC.rd(sa(0, SLOT_STS), r);
      chk(r & 16'h4000, 16'h4000);
      scaleState.normal <= 1'b0;
      upd();
      PLC.rd(sa(0, SLOT_WGT), r);
      chk(r, 16'h0000);
      PLC.rd(sa(0, SLOT_STS), r);
      chk(r & 16'h8000, 16'h0000);
      scaleState.normal <= 1'b1;
      done("status");
      cm(16'h8018);
      chk({tareValue[14:0], netMode}, 16'h0000);
      scaleState.motion <= 1'b1;
      cm(16'h8038);
      chk({6'h00, seen, netMode}, 16'h0000);
      scaleState.motion <= 1'b0;
      cm(16'h8018);
      cm(16'h8038);
      chk(tareValue, 16'h0101);
      PLC.wr(sa(1, SLOT_CMD), 16'h0010);
      upd();
      chk(tareValue, 16'h0101);
      cm(16'h81f8);
      chk({7'h00, seen}, 16'h0038);
      cm(16'h80f8);
      chk({7'h00, seen}, 16'h0004);
      outputsOwned <= 3'h2;
      // Output bits act from the command latched at an update
      cm(16'hd0f8);
      chk({13'h0, hwOutputs}, 16'h0005);
      ownOutputs <= 3'h2;
      repeat (3) @(posedge core_clk);
      chk({13'h0, hwOutputs}, 16'h0007);
      done("commands");
      scaleState.enterKey <= 1'b1;
      upd();
      scaleState.enterKey <= 1'b0;
      PLC.rd(sa(0, SLOT_STS), r);
      chk(r & 16'h0100, 16'h0100);
      for (int c = 1; c < 8; c++) begin
         cm(16'h80f8);
         cm(16'h80f8 | 16'(c << 9));
         chk({13'h0, messageCode}, 16'(c));
         if (c == 6) chk({15'h0, promptStartTrigger}, 16'h0001);
      end
      PLC.rd(sa(0, SLOT_STS), r);
      chk(r & 16'h0100, 16'h0000);
      done("message");
      PLC.wr(OFS_CTRL, 16'h0004);
      upd();
      PLC.rd(sa(1, SLOT_WGT), r);
      chk(r, 16'h0000);
      chk({15'h0, divisionFormat}, 16'h0001);
      PLC.rd(8'h50, r);
      chk(r, 16'h0000);
      PLC.rd(OFS_CTRL, r);
      chk(r, 16'h0004);
      PLC.rd(OFS_STAT, r);
      chk(r, 16'h0002);
      PLC.wr(OFS_TARE, 16'hffff);
      @(posedge core_clk);
      chk(tareValue, 16'h0101);
      done("map");
      end_sim();
   end
endmodule : tb_scale_integer_slot_interface
bind scale_integer_slot_interface slot_iface_checker CHK (.core_clk, .nrst, .addr, .wrData,
   .wrStb, .rdStb, .rdData, .updateTick, .weights, .scaleState, .outputsOwned, .ownOutputs,
   .hwOutputs, .cmdPulses, .tareValue, .targetValue, .netMode, .messageCode,
   .promptStartTrigger, .divisionFormat);
`default_nettype wire
